// >>> design/ess_pkg.sv
package ess_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 8;
	localparam int SEQ_ENTRIES = 3;
	localparam int SEQ_BYTES = 9;

	localparam logic [15:0] OFS_GEN_INSTR = 16'h0E28;
	localparam logic [15:0] OFS_GEN_ADDR_A = 16'h0E29;
	localparam logic [15:0] OFS_GEN_ADDR_B = 16'h0E2A;
	localparam logic [15:0] OFS_ANA_INSTR = 16'h0E2B;
	localparam logic [15:0] OFS_ANA_ADDR_A = 16'h0E2C;
	localparam logic [15:0] OFS_ANA_ADDR_B = 16'h0E2D;
	localparam logic [15:0] OFS_DIV_INSTR = 16'h0E2E;
	localparam logic [15:0] OFS_DIV_ADDR_A = 16'h0E2F;
	localparam logic [15:0] OFS_DIV_ADDR_B = 16'h0E30;
	localparam logic [15:0] OFS_CTRL = 16'h0E50;
	localparam logic [15:0] OFS_STAT = 16'h0E51;
	localparam logic [15:0] OFS_PTR_LO = 16'h0E52;
	localparam logic [15:0] OFS_PTR_HI = 16'h0E53;

	localparam logic [7:0] RST_GEN_INSTR = 8'h1E;
	localparam logic [15:0] RST_GEN_ADDR = 16'h0400;
	localparam logic [7:0] RST_ANA_INSTR = 8'h0E;
	localparam logic [15:0] RST_ANA_ADDR = 16'h0430;
	localparam logic [7:0] RST_DIV_INSTR = 8'h33;
	localparam logic [15:0] RST_DIV_ADDR = 16'h0440;
	localparam logic [15:0] RST_EE_PTR = 16'h0000;

	localparam int CTRL_START_BIT = 0;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam logic [1:0] CSUM_ENTRY = 2'h0;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} ess_word_s;

	typedef enum logic [2:0] {
		S_IDLE, S_INSTR, S_ADDR_HI, S_ADDR_LO, S_RD, S_DATA, S_CSUM, S_NEXT
	} ess_state_e;
endpackage

// >>> design/ess_seq.sv
`timescale 1ns/1ps

module ess_fifo #(
	parameter int W = 24,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [W-1:0] mem_r [DEPTH];
	logic [W-1:0] mem_nxt [DEPTH];
	logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [PW:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in_ready = (cnt_r != (PW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rp_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		cnt_nxt = cnt_r;
		if (push) begin
			wp_nxt = (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
		end
		if (pop) begin
			rp_nxt = (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_nxt[i] = mem_r[i];
		end
		if (push) begin
			mem_nxt[wp_r] = in_data;
		end
	end

	// storage has no reset; only the pointers and the count guard it
	always_ff @(posedge clk) begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_r[i] <= mem_nxt[i];
		end
	end
endmodule

// Operation
// RULE1: instruction byte N orders a copy of N plus one bytes.
// RULE2: copy start address comes from the two bytes after the instruction.
// RULE3: instruction byte is written to the eeprom first, pointer plus one.
// RULE4: then the two address bytes are written, pointer plus two.
// RULE5: then the ordered register-map bytes are copied, pointer advancing past them.
// RULE6: general settings entry advances pointer by 32: 31 data plus checksum.
// RULE7: entry at 0x0E28 defaults to 31 bytes from 0x0400.
// RULE8: entry at 0x0E2B defaults to 0x0E, 15 bytes from 0x0430.
// RULE9: 0x0430 bytes are analog loop zero and channel zero driver settings.
// RULE10: entry at 0x0E2E defaults to 0x33, 52 bytes from 0x0440.
// RULE11: 0x0440 bytes are digital loop zero divider and loop bandwidth settings.
// RULE12: entries run in ascending order, each finished before the next.
// RULE13: count follows instruction plus one; checksum byte is added explicitly.
module ess_seq
	import ess_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	output logic [ADDR_W-1:0] map_addr,
	output logic map_rd,
	input wire logic [DATA_W-1:0] map_rdata,
	output logic ee_valid,
	input wire logic ee_ready,
	output ess_word_s ee_word
);
	logic [DATA_W-1:0] seq_r [SEQ_BYTES];
	logic [DATA_W-1:0] seq_nxt [SEQ_BYTES];
	logic [DATA_W-1:0] rdata_r, rdata_nxt;
	ess_state_e state_r, state_nxt;
	logic [1:0] ent_r, ent_nxt;
	logic [7:0] cnt_r, cnt_nxt;
	logic [ADDR_W-1:0] maddr_r, maddr_nxt;
	logic [ADDR_W-1:0] ptr_r, ptr_nxt;
	logic [DATA_W-1:0] csum_r, csum_nxt;
	logic done_r, done_nxt;
	logic push_valid, push_ready;
	ess_word_s push_word;
	logic [15:0] rel;
	logic in_seq;
	logic [3:0] idx;
	logic [SEQ_BYTES-1:0] seq_we;
	logic busy;
	logic [DATA_W-1:0] cur_instr;
	logic [DATA_W-1:0] cur_addr_a;
	logic [DATA_W-1:0] cur_addr_b;
	logic last_ent;
	logic csum_ent;
	logic start;

	// register bus decode
	assign rel = reg_addr - OFS_GEN_INSTR;
	assign in_seq = (reg_addr >= OFS_GEN_INSTR) && (reg_addr <= OFS_DIV_ADDR_B);
	assign idx = rel[3:0];
	assign busy = (state_r != S_IDLE);
	// start is ignored while busy; a second strobe cannot reset the pointer
	assign start = reg_wr && (reg_addr == OFS_CTRL) &&
		reg_wdata[CTRL_START_BIT] && !busy;

	always_comb begin
		seq_we = '0;
		if (reg_wr && in_seq) begin
			seq_we[idx] = 1'b1;
		end
	end

	// each entry holds instruction, address high, address low; a plain
	// select keeps the index away from an adder and a multiplier
	always_comb begin
		case (ent_r)
			2'h0: begin
				cur_instr = seq_r[0];
				cur_addr_a = seq_r[1];
				cur_addr_b = seq_r[2];
			end
			2'h1: begin
				cur_instr = seq_r[3];
				cur_addr_a = seq_r[4];
				cur_addr_b = seq_r[5];
			end
			2'h2: begin
				cur_instr = seq_r[6];
				cur_addr_a = seq_r[7];
				cur_addr_b = seq_r[8];
			end
			default: begin
				cur_instr = '0;
				cur_addr_a = '0;
				cur_addr_b = '0;
			end
		endcase
	end

	assign last_ent = (ent_r == 2'(SEQ_ENTRIES-1));
	assign csum_ent = (ent_r == CSUM_ENTRY);

	always_comb begin
		for (int i = 0; i < SEQ_BYTES; i++) begin
			seq_nxt[i] = seq_r[i];
		end
		// entries stay writable while saving; count and address of the running entry are latched once its address low byte is pushed
		for (int i = 0; i < SEQ_BYTES; i++) begin
			if (seq_we[i]) begin
				seq_nxt[i] = reg_wdata;
			end
		end
		rdata_nxt = '0;
		if (reg_rd) begin
			if (in_seq) begin
				rdata_nxt = seq_r[idx];
			end else begin
				case (reg_addr)
					OFS_STAT: begin
						rdata_nxt[STAT_BUSY_BIT] = busy;
						rdata_nxt[STAT_DONE_BIT] = done_r;
					end
					OFS_PTR_LO: rdata_nxt = ptr_r[7:0];
					OFS_PTR_HI: rdata_nxt = ptr_r[15:8];
					default: rdata_nxt = '0;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			seq_r[0] <= RST_GEN_INSTR; // RULE7
			seq_r[1] <= RST_GEN_ADDR[15:8]; // RULE7
			seq_r[2] <= RST_GEN_ADDR[7:0]; // RULE7
			seq_r[3] <= RST_ANA_INSTR; // RULE8
			seq_r[4] <= RST_ANA_ADDR[15:8]; // RULE8 RULE9
			seq_r[5] <= RST_ANA_ADDR[7:0]; // RULE8 RULE9
			seq_r[6] <= RST_DIV_INSTR; // RULE10
			seq_r[7] <= RST_DIV_ADDR[15:8]; // RULE10 RULE11
			seq_r[8] <= RST_DIV_ADDR[7:0]; // RULE10 RULE11
			rdata_r <= '0;
		end else begin
			for (int i = 0; i < SEQ_BYTES; i++) begin
				seq_r[i] <= seq_nxt[i];
			end
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;

	// the stream strobe depends on the state alone, the map read also on fifo room;
	// the next-state block below only decides when a step is finished
	always_comb begin
		push_valid = 1'b0;
		push_word = '0;
		map_rd = 1'b0;
		case (state_r)
			S_INSTR: begin
				push_valid = 1'b1;
				push_word = '{addr: ptr_r, data: cur_instr}; // RULE3
			end
			S_ADDR_HI: begin
				push_valid = 1'b1;
				push_word = '{addr: ptr_r, data: cur_addr_a}; // RULE4
			end
			S_ADDR_LO: begin
				push_valid = 1'b1;
				push_word = '{addr: ptr_r, data: cur_addr_b}; // RULE4
			end
			S_RD: begin
				// read only with room, so the one-cycle answer is never dropped
				map_rd = push_ready; // RULE5
			end
			S_DATA: begin
				push_valid = 1'b1;
				push_word = '{addr: ptr_r, data: map_rdata}; // RULE5
			end
			S_CSUM: begin
				push_valid = 1'b1;
				push_word = '{addr: ptr_r, data: csum_r}; // RULE6 RULE13
			end
			default: begin
				push_valid = 1'b0;
				push_word = '0;
				map_rd = 1'b0;
			end
		endcase
	end

	// sequencer
	always_comb begin
		state_nxt = state_r;
		ent_nxt = ent_r;
		cnt_nxt = cnt_r;
		maddr_nxt = maddr_r;
		ptr_nxt = ptr_r;
		csum_nxt = csum_r;
		done_nxt = done_r;
		case (state_r)
			S_IDLE: begin
				if (start) begin
					state_nxt = S_INSTR;
					ent_nxt = '0;
					ptr_nxt = RST_EE_PTR;
					done_nxt = 1'b0;
				end
			end
			S_INSTR: begin
				if (push_ready) begin
					ptr_nxt = ptr_r + 16'h0001; // RULE3
					state_nxt = S_ADDR_HI;
				end
			end
			S_ADDR_HI: begin
				if (push_ready) begin
					ptr_nxt = ptr_r + 16'h0001; // RULE4
					state_nxt = S_ADDR_LO;
				end
			end
			S_ADDR_LO: begin
				if (push_ready) begin
					ptr_nxt = ptr_r + 16'h0001; // RULE4
					maddr_nxt = {cur_addr_a, cur_addr_b}; // RULE2
					cnt_nxt = cur_instr; // RULE1 RULE13
					csum_nxt = '0;
					state_nxt = S_RD;
				end
			end
			S_RD: begin
				if (push_ready) begin
					state_nxt = S_DATA;
				end
			end
			S_DATA: begin
				// room was checked before the read; no push since
				ptr_nxt = ptr_r + 16'h0001; // RULE5
				maddr_nxt = maddr_r + 16'h0001;
				csum_nxt = csum_r + map_rdata;
				if (cnt_r == 8'h00) begin
					// count runs from N down to 0: N plus one bytes
					state_nxt = csum_ent ? S_CSUM : S_NEXT; // RULE1
				end else begin
					cnt_nxt = cnt_r - 8'h01;
					state_nxt = S_RD;
				end
			end
			S_CSUM: begin
				if (push_ready) begin
					ptr_nxt = ptr_r + 16'h0001; // RULE6
					state_nxt = S_NEXT;
				end
			end
			S_NEXT: begin
				if (last_ent) begin
					state_nxt = S_IDLE;
					done_nxt = 1'b1;
				end else begin
					ent_nxt = ent_r + 2'h1; // RULE12
					state_nxt = S_INSTR;
				end
			end
			default: state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= S_IDLE;
			ent_r <= '0;
			cnt_r <= '0;
			maddr_r <= '0;
			ptr_r <= RST_EE_PTR;
			csum_r <= '0;
			done_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ent_r <= ent_nxt;
			cnt_r <= cnt_nxt;
			maddr_r <= maddr_nxt;
			ptr_r <= ptr_nxt;
			csum_r <= csum_nxt;
			done_r <= done_nxt;
		end
	end

	assign map_addr = maddr_r;

	ess_fifo #(
		.W($bits(ess_word_s)),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(clk),
		.nrst(nrst),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_word),
		.out_valid(ee_valid),
		.out_ready(ee_ready),
		.out_data(ee_word)
	);
endmodule

// >>> tb/ess_ee_model.sv
`timescale 1ns/1ps
module ess_ee_model
	import ess_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic slow,
	input wire logic [15:0] map_addr,
	output logic [7:0] map_rdata,
	input wire logic ee_valid,
	output logic ee_ready,
	input wire ess_word_s ee_word,
	output int taken
);
	logic [7:0] mem [256];
	logic [3:0] cnt;
	// slow takes one word in 16, so the fifo fills and refuses
	assign ee_ready = slow ? cnt == 4'h0 : cnt[1:0] != 2'h0;
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 4'h0;
			taken <= 0;
		end else begin
			cnt <= cnt + 4'h1;
			if (ee_valid && ee_ready) begin
				mem[ee_word.addr[7:0]] <= ee_word.data;
				taken <= taken + 1;
			end
		end
	end
	// data follow the address every cycle, so a late sample reads wrong
	always @(posedge clk)
		map_rdata <= map_addr[7:0] ^ 8'hA5;
endmodule

// >>> tb/ess_seq_assertions.sv
`timescale 1ns/1ps
module ess_seq_checker
	import ess_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic map_rd,
	input wire logic ee_valid,
	input wire logic ee_ready,
	input wire ess_word_s ee_word
);
	logic [15:0] last_r;
	logic seen_r;
	logic [7:0] gi_r;
	logic take;
	assign take = ee_valid && ee_ready;
	// shadow of the first instruction; follows every software write to it
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			last_r <= 16'h0000;
			seen_r <= 1'b0;
			gi_r <= RST_GEN_INSTR;
		end else begin
			if (take)
				last_r <= ee_word.addr;
			if (take)
				seen_r <= 1'b1;
			if (reg_wr && reg_addr == OFS_GEN_INSTR)
				gi_r <= reg_wdata;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata");
	property p_gi_rd;
		$past(reg_rd) && $past(reg_addr) == OFS_GEN_INSTR |-> reg_rdata == gi_r;
	endproperty
	a_gi_rd: assert property (p_gi_rd) else $error("instr read");
	property p_ctl_rd;
		$past(reg_rd) && ($past(reg_addr) == OFS_CTRL
			|| $past(reg_addr) == 16'h0E40) |-> reg_rdata == 8'h00;
	endproperty
	a_ctl_rd: assert property (p_ctl_rd) else $error("ctrl read");
	property p_map_gap; map_rd |=> !map_rd; endproperty
	a_map_gap: assert property (p_map_gap) else $error("map gap");
	property p_hold; ee_valid && !ee_ready |=> ee_valid && $stable(ee_word);
	endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_ptr;
		take && seen_r |-> ee_word.addr == last_r + 16'h0001
			|| ee_word.addr == 16'h0000;
	endproperty
	a_ptr: assert property (p_ptr) else $error("ptr step");
	property p_first; take && ee_word.addr == 16'h0000 |-> ee_word.data == gi_r;
	endproperty
	a_first: assert property (p_first) else $error("first");
	property p_rst; !$past(nrst) |-> !ee_valid && !map_rd; endproperty
	a_rst: assert property (p_rst) else $error("idle");
	c_take: cover property (take);
	c_stall: cover property (ee_valid && !ee_ready [*8]);
	c_map: cover property (map_rd ##2 map_rd);
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import ess_pkg::*;
;
	logic clk, nrst, reg_wr, reg_rd, map_rd, ee_valid, ee_ready, slow;
	logic [15:0] reg_addr, map_addr;
	logic [7:0] reg_wdata, reg_rdata, map_rdata, v;
	ess_word_s ee_word;
	int taken, bad_count, compares, cyc, pos, n0;
	logic [7:0] ins [3];
	logic [15:0] ad [3];
	ess_seq ess_seq_i (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .map_addr, .map_rd, .map_rdata, .ee_valid, .ee_ready,
		.ee_word);
	ess_ee_model ess_ee_model_i (.clk, .nrst, .slow, .map_addr, .map_rdata,
		.ee_valid, .ee_ready, .ee_word, .taken);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count++;
			end_of_test();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic put(input logic [7:0] d);
		chk(ess_ee_model_i.mem[pos[7:0]], d);
		pos++;
	endtask
	task automatic run_check();
		logic [7:0] s, sum, d;
		pos = 0;
		n0 = taken;
		s = 8'h00;
		wr(OFS_CTRL, 8'h01);
		wr(OFS_CTRL, 8'h01);
		rd(OFS_STAT, s);
		chk(s, 8'(1 << STAT_BUSY_BIT));
		while (!s[STAT_DONE_BIT])
			rd(OFS_STAT, s);
		chk(s, 8'(1 << STAT_DONE_BIT));
		while (ee_valid)
			@(posedge clk);
		for (int e = 0; e < 3; e++) begin
			put(ins[e]);
			put(ad[e][15:8]);
			put(ad[e][7:0]);
			sum = 8'h00;
			for (int k = 0; k <= int'(ins[e]); k++) begin
				d = (ad[e][7:0] + 8'(k)) ^ 8'hA5;
				sum += d;
				put(d);
			end
			if (e == 0)
				put(sum);
		end
		rd(OFS_PTR_LO, s);
		chk(s, pos[7:0]);
		rd(OFS_PTR_HI, s);
		chk(s, pos[15:8]);
		chk(16'(taken - n0), pos[15:0]);
	endtask
	task automatic end_of_test();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		cyc = 0;
		bad_count = 0;
		compares = 0;
		nrst = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		slow = 1'b1;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		ins = '{RST_GEN_INSTR, RST_ANA_INSTR, RST_DIV_INSTR};
		ad = '{RST_GEN_ADDR, RST_ANA_ADDR, RST_DIV_ADDR};
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			rd(OFS_GEN_INSTR + 16'(i), v);
			chk(v, i % 3 == 0 ? ins[i / 3] : i % 3 == 1 ? ad[i / 3][15:8]
				: ad[i / 3][7:0]);
		end
		wr(16'h0E40, 8'h5A);
		rd(16'h0E40, v);
		chk(v, 8'h00);
		run_check();
		chk(pos[15:0], 16'h006C);
		slow <= 1'b0;
		ins[1] = 8'h00;
		ad[1] = 16'h12FF;
		wr(OFS_ANA_INSTR, 8'h00);
		wr(OFS_ANA_ADDR_A, 8'h12);
		wr(OFS_ANA_ADDR_B, 8'hFF);
		run_check();
		end_of_test();
	end
endmodule
bind ess_seq ess_seq_checker ess_seq_checker_i (.clk, .nrst, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .map_rd, .ee_valid, .ee_ready,
	.ee_word);
